// File: pmfo_regs.svh
`ifndef PMFO_REGS_SVH
`define PMFO_REGS_SVH

`define PMFO_ADDR_W 8
`define PMFO_CTRL_OFF 8'ha0
`define PMFO_SMIEN_OFF 8'ha2
`define PMFO_EVEN_OFF 8'ha4
`define PMFO_START_OFF 8'ha8
`define PMFO_STAT_OFF 8'haa

`define PMFO_CTRL_RST 8'h08
`define PMFO_CTRL_MASK 8'h0f
`define PMFO_SMIEN_RST 8'h00
`define PMFO_EVEN_RST 32'h00000000
`define PMFO_START_RST 8'h0f
`define PMFO_STAT_RST 8'h00

`define PMFO_CTRL_GATE 0
`define PMFO_CTRL_HALTEN 1
`define PMFO_CTRL_FREEZE 3

`define PMFO_EV_SMI 31
`define PMFO_EV_INTR 30
`define PMFO_EV_NMI 29
`define PMFO_EV_SERIAL 27
`define PMFO_EV_PRINTER 26
`define PMFO_EV_DRIVE 25
`define PMFO_EV_XFER 24
`define PMFO_EV_LINE_MASK 32'h0000fffb
`define PMFO_EV_APIC_MASK 32'h4f000000
`define PMFO_EV_BASE_MASK 32'ha000fffb

`define PMFO_ST_IRQ1 0
`define PMFO_ST_IRQ3 1
`define PMFO_ST_IRQ4 2
`define PMFO_ST_IRQ8 3
`define PMFO_ST_IRQ12 4
`define PMFO_ST_TIMER 5
`define PMFO_ST_EXT 6
`define PMFO_ST_PORT 7

`define PMFO_MINUTE_S 60
`define PMFO_CLK_HZ 100000000

`endif

// File: pmfo_pkg.sv
package pmfo_pkg;

    typedef enum logic [1:0] {
        PMFO_RUN,
        PMFO_WAIT_GRANT,
        PMFO_HALTED
    } pmfo_state_t;

    typedef struct packed {
        logic [15:0] irq;
        logic nmi;
        logic intr;
        logic serial;
        logic printer;
        logic drive;
        logic xfer;
        logic init;
        logic extSmiN;
    } pmfo_pins_t;

endpackage

// File: pmfo_prescale.sv
`timescale 1ns/10ps
`include "pmfo_regs.svh"

module pmfo_prescale #(
    parameter logic [35:0] CYCLES =
        36'(`PMFO_MINUTE_S) * 36'(`PMFO_CLK_HZ)
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);

    logic [35:0] count_q;
    logic tick_q;

    // free-running so the minute grid ignores freeze
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_q <= 36'h0;
            tick_q <= 1'b0;
        end
        else if (count_q == CYCLES - 36'h1)
        begin
            count_q <= 36'h0;
            tick_q <= 1'b1;
        end
        else
        begin
            count_q <= count_q + 36'h1;
            tick_q <= 1'b0;
        end
    end

    assign tick = tick_q;

endmodule // pmfo_prescale

// File: pmfo_top.sv
`timescale 1ns/10ps
`include "pmfo_regs.svh"

// Behaviour
// - enabled system event reloads idle timer
// - enabled break event while stopped releases halt
// - halt held until stop-grant cycle arrives
// - early break events latched, applied at grant
// - init breaks only after stop-grant
// - bit 31 enables sysmgmt activity both ways
// - bit 29 enables nonmaskable activity both ways
// - bit 30 cpu interrupt break only, variant
// - bits 27..24 peripheral system events, variant
// - bits 15:3,1:0 request lines both ways
// - unfrozen timer decrements once per minute
// - timer at zero raises interrupt, reloads
// - start value resets 0fh, reads written
// - enabled cause sets its status bit
// - hardware set beats software clear
// - irq status bits set on rising edge only, ext on falling edge
// - status bits independent of each other, gate
// - bit 7 power port write status
// - freeze bit stops the timer
// - gate masks output, pending asserts at once
module pmfo_top #(
    parameter logic ADVANCED_INTC = 1'b0,
    parameter logic [35:0] MINUTE_CYCLES =
        36'(`PMFO_MINUTE_S) * 36'(`PMFO_CLK_HZ)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`PMFO_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire pmfo_pkg::pmfo_pins_t pins,
    input wire logic stopGrant,
    input wire logic powerPortWr,
    input wire logic powerPortRd,
    output logic cpuClockHaltN,
    output logic sysmgmtIrqN
);

    localparam logic [31:0] EV_MASK = ADVANCED_INTC ?
        (`PMFO_EV_BASE_MASK | `PMFO_EV_APIC_MASK) : `PMFO_EV_BASE_MASK;

    pmfo_pkg::pmfo_pins_t pinMeta_q;
    pmfo_pkg::pmfo_pins_t pinSync_q;
    pmfo_pkg::pmfo_pins_t pinPrev_q;
    pmfo_pkg::pmfo_pins_t pinRise;
    pmfo_pkg::pmfo_state_t state_q;
    pmfo_pkg::pmfo_state_t state_d;

    logic [7:0] ctrl_q;
    logic [7:0] smiEn_q;
    logic [31:0] evEn_q;
    logic [7:0] start_q;
    logic [7:0] count_q;
    logic [7:0] status_q;
    logic [7:0] statusSet;
    logic [31:0] rdata_q;
    logic irqN_q;
    logic haltN_q;
    logic breakLatch_q;
    logic smiPrev_q;
    logic minuteTick;
    logic wrCtrl;
    logic wrSmiEn;
    logic wrEvEn;
    logic wrStart;
    logic wrStat;
    logic smiRise;
    logic extFall;
    logic expire;
    logic sysEvent;
    logic breakEvent;
    logic initBreak;
    logic haltReq;
    logic smiPending;

    // pins come from outside the clock domain
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
            pinPrev_q <= '0;
        end
        else
        begin
            pinMeta_q <= pins;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    assign pinRise = pinSync_q & ~pinPrev_q;
    assign extFall = pinPrev_q.extSmiN & ~pinSync_q.extSmiN;

    pmfo_prescale #(
        .CYCLES(MINUTE_CYCLES)
    ) u_prescale (
        .clk(clk),
        .rst(rst),
        .tick(minuteTick)
    );

    assign wrCtrl = regWr && (regAddr == `PMFO_CTRL_OFF);
    assign wrSmiEn = regWr && (regAddr == `PMFO_SMIEN_OFF);
    assign wrEvEn = regWr && (regAddr == `PMFO_EVEN_OFF);
    assign wrStart = regWr && (regAddr == `PMFO_START_OFF);
    assign wrStat = regWr && (regAddr == `PMFO_STAT_OFF);

    // power port write drops the halt enable
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_q <= `PMFO_CTRL_RST;
        end
        else if (wrCtrl)
        begin
            ctrl_q <= regWdata[7:0] & `PMFO_CTRL_MASK;
        end
        else if (powerPortWr)
        begin
            ctrl_q[`PMFO_CTRL_HALTEN] <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            smiEn_q <= `PMFO_SMIEN_RST;
        end
        else if (wrSmiEn)
        begin
            smiEn_q <= regWdata[7:0];
        end
    end

    // reserved enable bits never store
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            evEn_q <= `PMFO_EVEN_RST;
        end
        else if (wrEvEn)
        begin
            evEn_q <= regWdata & EV_MASK;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            start_q <= `PMFO_START_RST;
        end
        else if (wrStart)
        begin
            start_q <= regWdata[7:0];
        end
    end

    // sysmgmt activity seen as rise of the gated request
    assign smiPending = |status_q;
    assign smiRise = ~irqN_q & smiPrev_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            smiPrev_q <= 1'b1;
        end
        else
        begin
            smiPrev_q <= irqN_q;
        end
    end

    always_comb
    begin
        sysEvent = |(pinRise.irq & evEn_q[15:0]);
        sysEvent = sysEvent | (smiRise & evEn_q[`PMFO_EV_SMI]);
        sysEvent = sysEvent | (pinRise.nmi & evEn_q[`PMFO_EV_NMI]);
        sysEvent = sysEvent
            | (pinRise.serial & evEn_q[`PMFO_EV_SERIAL])
            | (pinRise.printer & evEn_q[`PMFO_EV_PRINTER])
            | (pinRise.drive & evEn_q[`PMFO_EV_DRIVE])
            | (pinRise.xfer & evEn_q[`PMFO_EV_XFER]);
    end

    always_comb
    begin
        breakEvent = |(pinRise.irq & evEn_q[15:0]);
        breakEvent = breakEvent | (smiRise & evEn_q[`PMFO_EV_SMI]);
        breakEvent = breakEvent
            | (pinRise.nmi & evEn_q[`PMFO_EV_NMI]);
        breakEvent = breakEvent
            | (pinRise.intr & evEn_q[`PMFO_EV_INTR]);
    end

    // zero writes to start value fire every cycle; software keeps off it
    assign expire = (count_q == 8'h00) && !ctrl_q[`PMFO_CTRL_FREEZE];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_q <= `PMFO_START_RST;
        end
        else if (sysEvent || expire)
        begin
            count_q <= start_q;
        end
        else if (minuteTick && !ctrl_q[`PMFO_CTRL_FREEZE])
        begin
            count_q <= count_q - 8'h01;
        end
    end

    always_comb
    begin
        statusSet = 8'h00;
        statusSet[`PMFO_ST_IRQ1] = pinRise.irq[1];
        statusSet[`PMFO_ST_IRQ3] = pinRise.irq[3];
        statusSet[`PMFO_ST_IRQ4] = pinRise.irq[4];
        statusSet[`PMFO_ST_IRQ8] = pinRise.irq[8];
        statusSet[`PMFO_ST_IRQ12] = pinRise.irq[12];
        statusSet[`PMFO_ST_TIMER] = expire;
        statusSet[`PMFO_ST_EXT] = extFall;
        statusSet[`PMFO_ST_PORT] = powerPortWr;
        statusSet = statusSet & smiEn_q;
    end

    // per-bit clear by writing 0; set wins
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            status_q <= `PMFO_STAT_RST;
        end
        else if (wrStat)
        begin
            status_q <= (status_q & regWdata[7:0]) | statusSet;
        end
        else
        begin
            status_q <= status_q | statusSet;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irqN_q <= 1'b1;
        end
        else
        begin
            irqN_q <= !(ctrl_q[`PMFO_CTRL_GATE] && smiPending);
        end
    end

    assign haltReq = powerPortRd && ctrl_q[`PMFO_CTRL_HALTEN];
    // level of init counts only once the grant has come
    assign initBreak = pinSync_q.init && (state_q == pmfo_pkg::PMFO_HALTED);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            pmfo_pkg::PMFO_RUN:
            begin
                if (haltReq)
                begin
                    state_d = pmfo_pkg::PMFO_WAIT_GRANT;
                end
            end
            pmfo_pkg::PMFO_WAIT_GRANT:
            begin
                if (stopGrant)
                begin
                    state_d = (breakLatch_q || breakEvent) ?
                        pmfo_pkg::PMFO_RUN :
                        pmfo_pkg::PMFO_HALTED;
                end
            end
            pmfo_pkg::PMFO_HALTED:
            begin
                if (breakEvent || initBreak ||
                    !ctrl_q[`PMFO_CTRL_HALTEN])
                begin
                    state_d = pmfo_pkg::PMFO_RUN;
                end
            end
            default:
            begin
                state_d = pmfo_pkg::PMFO_RUN;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= pmfo_pkg::PMFO_RUN;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            breakLatch_q <= 1'b0;
        end
        else if (state_q != pmfo_pkg::PMFO_WAIT_GRANT)
        begin
            breakLatch_q <= 1'b0;
        end
        else if (breakEvent)
        begin
            breakLatch_q <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            haltN_q <= 1'b1;
        end
        else
        begin
            haltN_q <= (state_d == pmfo_pkg::PMFO_RUN);
        end
    end

    // narrow registers read zero above their width
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_q <= 32'h00000000;
        end
        else if (regRd)
        begin
            unique case (regAddr)
                `PMFO_CTRL_OFF: rdata_q <= {24'h000000, ctrl_q};
                `PMFO_SMIEN_OFF: rdata_q <= {24'h000000, smiEn_q};
                `PMFO_EVEN_OFF: rdata_q <= evEn_q;
                `PMFO_START_OFF: rdata_q <= {24'h000000, start_q};
                `PMFO_STAT_OFF: rdata_q <= {24'h000000, status_q};
                default: rdata_q <= 32'h00000000;
            endcase
        end
        else
        begin
            rdata_q <= 32'h00000000;
        end
    end

    assign regRdata = rdata_q;
    assign cpuClockHaltN = haltN_q;
    assign sysmgmtIrqN = irqN_q;

endmodule // pmfo_top

// File: pmfo_checker.sv
`timescale 1ns/10ps
`include "pmfo_regs.svh"
module pmfo_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`PMFO_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic stopGrant,
    input wire logic powerPortWr,
    input wire logic powerPortRd,
    input wire logic cpuClockHaltN,
    input wire logic sysmgmtIrqN
);
    logic [7:0] ctrlQ;
    logic [7:0] startQ;
    logic seenQ;
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrlQ <= `PMFO_CTRL_RST;
        else if (regWr && regAddr == `PMFO_CTRL_OFF)
            ctrlQ <= regWdata[7:0] & `PMFO_CTRL_MASK;
        else if (powerPortWr)
            ctrlQ[1] <= 1'b0;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            startQ <= `PMFO_START_RST;
        else if (regWr && regAddr == `PMFO_START_OFF)
            startQ <= regWdata[7:0];
    end
    // grant seen while halted; cleared on release
    always_ff @(posedge clk)
    begin
        if (rst || cpuClockHaltN)
            seenQ <= 1'b0;
        else if (stopGrant)
            seenQ <= 1'b1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data not idle");
    AST_CTRL_RD: assert property ($past(regRd) &&
        $past(regAddr) == `PMFO_CTRL_OFF |->
        regRdata == {24'h0, $past(ctrlQ)})
        else $error("control readback wrong");
    AST_START_RD: assert property ($past(regRd) &&
        $past(regAddr) == `PMFO_START_OFF |->
        regRdata == {24'h0, $past(startQ)})
        else $error("start value readback wrong");
    AST_STAT_RSVD: assert property ($past(regRd) &&
        $past(regAddr) == `PMFO_STAT_OFF |-> regRdata[31:8] == 24'h0)
        else $error("status reserved bits set");
    AST_EVEN_RSVD: assert property ($past(regRd) &&
        $past(regAddr) == `PMFO_EVEN_OFF |->
        (regRdata & 32'h10ff0004) == 32'h0)
        else $error("enable reserved bits set");
    AST_GATE: assert property (!$past(ctrlQ[0]) |-> sysmgmtIrqN)
        else $error("interrupt not masked");
    AST_HALT_GO: assert property (powerPortRd && ctrlQ[1] &&
        cpuClockHaltN |=> !cpuClockHaltN)
        else $error("halt not asserted");
    AST_HALT_HOLD: assert property (!cpuClockHaltN && !seenQ &&
        !stopGrant |=> !cpuClockHaltN)
        else $error("halt released before grant");
    cover property ($rose(cpuClockHaltN));
    cover property ($fell(sysmgmtIrqN));
    cover property (stopGrant && !cpuClockHaltN);
endmodule // pmfo_checker

bind pmfo_top pmfo_checker u_chk (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .stopGrant(stopGrant), .powerPortWr(powerPortWr),
    .powerPortRd(powerPortRd), .cpuClockHaltN(cpuClockHaltN),
    .sysmgmtIrqN(sysmgmtIrqN));

// File: pmfo_cpu_model.sv
`timescale 1ns/10ps
module pmfo_cpu_model #(
    parameter int GRANT_DELAY = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic haltN,
    output logic grant
);
    int cnt;
    // one grant per halt; slow answer set by GRANT_DELAY
    always @(posedge clk)
    begin
        if (rst || haltN)
        begin
            cnt <= 0;
            grant <= 1'b0;
        end
        else
        begin
            cnt <= (cnt > GRANT_DELAY) ? cnt : cnt + 1;
            grant <= (cnt == GRANT_DELAY);
        end
    end
endmodule // pmfo_cpu_model

// File: pmfo_top_bench.sv
`timescale 1ns/10ps
`include "pmfo_regs.svh"
module pmfo_top_bench;
    logic clk;
    logic rst;
    logic [7:0] regAddr;
    logic [31:0] regWdata;
    logic regWr;
    logic regRd;
    logic [31:0] regRdata;
    pmfo_pkg::pmfo_pins_t pins;
    logic stopGrant;
    logic powerPortWr;
    logic powerPortRd;
    logic cpuClockHaltN;
    logic sysmgmtIrqN;
    logic rdSeen;
    logic [31:0] expQ[$];
    logic [31:0] rv;
    integer seed;
    int fails;
    int cmp_count;
    pmfo_top #(.ADVANCED_INTC(1'b0), .MINUTE_CYCLES(36'd20)) DUT (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pins(pins),
        .stopGrant(stopGrant), .powerPortWr(powerPortWr),
        .powerPortRd(powerPortRd), .cpuClockHaltN(cpuClockHaltN),
        .sysmgmtIrqN(sysmgmtIrqN));
    pmfo_cpu_model #(.GRANT_DELAY(12)) cpu (.clk(clk), .rst(rst),
        .haltN(cpuClockHaltN), .grant(stopGrant));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] got);
        cmp_count++;
        if (got !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        expQ.push_back(e);
        @(posedge clk);
        regRd <= 1'b0;
    endtask
    task automatic pulse(input logic toPortWr);
        @(posedge clk);
        if (toPortWr)
            powerPortWr <= 1'b1;
        else
            powerPortRd <= 1'b1;
        @(posedge clk);
        powerPortWr <= 1'b0;
        powerPortRd <= 1'b0;
    endtask
    // bounded wait, sampled after the edge has settled
    task automatic wait_for(ref logic s, input logic v, input int n);
        int i;
        i = 0;
        while (s !== v && i < n)
        begin
            @(posedge clk);
            #1;
            i++;
        end
    endtask
    always @(posedge clk) rdSeen <= regRd;
    always @(negedge clk)
    begin
        if (rdSeen === 1'b1)
            chk("regRdata", expQ.pop_front(), regRdata);
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #100000;
        fails++;
        close_out;
    end
    initial
    begin
        seed = 32'hb5ea;
        rst = 1'b1;
        regAddr = 8'h0;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        pins = '0;
        pins.extSmiN = 1'b1;
        powerPortWr = 1'b0;
        powerPortRd = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(`PMFO_CTRL_OFF, 32'(`PMFO_CTRL_RST));
        rd(`PMFO_SMIEN_OFF, 32'h0);
        rd(`PMFO_EVEN_OFF, `PMFO_EVEN_RST);
        rd(`PMFO_START_OFF, 32'(`PMFO_START_RST));
        rd(`PMFO_STAT_OFF, 32'h0);
        rd(8'ha6, 32'h0);
        $display("test reset done");
        // timer frozen from reset, so start writes are legal
        repeat (3)
        begin
            rv = $random(seed);
            wr(`PMFO_EVEN_OFF, rv);
            rd(`PMFO_EVEN_OFF, rv & `PMFO_EV_BASE_MASK);
            rv = $random(seed);
            rv[0] = 1'b1;
            wr(`PMFO_START_OFF, rv);
            rd(`PMFO_START_OFF, {24'h0, rv[7:0]});
        end
        $display("test registers done");
        wr(`PMFO_SMIEN_OFF, 32'h20);
        wr(`PMFO_START_OFF, 32'h2);
        wr(`PMFO_CTRL_OFF, 32'h1);
        wait_for(sysmgmtIrqN, 1'b0, 800);
        chk("sysmgmtIrqN", 32'h0, 32'(sysmgmtIrqN));
        wr(`PMFO_CTRL_OFF, 32'h9);
        rd(`PMFO_STAT_OFF, 32'h20);
        wr(`PMFO_STAT_OFF, 32'h0);
        rd(`PMFO_STAT_OFF, 32'h0);
        #1;
        chk("sysmgmtIrqN", 32'h1, 32'(sysmgmtIrqN));
        $display("test timer done");
        wr(`PMFO_SMIEN_OFF, 32'h1);
        @(posedge clk);
        pins.irq[1] <= 1'b1;
        repeat (6) @(posedge clk);
        rd(`PMFO_STAT_OFF, 32'h1);
        wr(`PMFO_STAT_OFF, 32'h0);
        repeat (6) @(posedge clk);
        rd(`PMFO_STAT_OFF, 32'h0);
        pins.irq[1] <= 1'b0;
        $display("test edge done");
        wr(`PMFO_EVEN_OFF, 32'h8);
        wr(`PMFO_CTRL_OFF, 32'ha);
        pulse(1'b0);
        @(posedge clk);
        pins.irq[3] <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk("cpuClockHaltN", 32'h0, 32'(cpuClockHaltN));
        wait_for(cpuClockHaltN, 1'b1, 40);
        chk("cpuClockHaltN", 32'h1, 32'(cpuClockHaltN));
        pins.irq[3] <= 1'b0;
        $display("test halt latched done");
        repeat (6) @(posedge clk);
        pulse(1'b0);
        @(posedge clk);
        pins.init <= 1'b1;
        repeat (3) @(posedge clk);
        pins.init <= 1'b0;
        repeat (25) @(posedge clk);
        #1;
        chk("cpuClockHaltN", 32'h0, 32'(cpuClockHaltN));
        @(posedge clk);
        pins.init <= 1'b1;
        wait_for(cpuClockHaltN, 1'b1, 10);
        chk("cpuClockHaltN", 32'h1, 32'(cpuClockHaltN));
        pins.init <= 1'b0;
        $display("test init done");
        wr(`PMFO_SMIEN_OFF, 32'hc0);
        pulse(1'b1);
        pins.extSmiN <= 1'b0;
        repeat (5) @(posedge clk);
        rd(`PMFO_STAT_OFF, 32'hc0);
        rd(`PMFO_CTRL_OFF, 32'h8);
        pins.extSmiN <= 1'b1;
        $display("test port done");
        close_out;
    end
endmodule // pmfo_top_bench
